// >>> ovcfg_pkg.sv
package ovcfg_pkg;
   localparam int unsigned N_INPUTS       = 24;
   localparam int unsigned N_SINK_INPUTS  = 10;
   localparam int unsigned N_ADC_BANK_IN  = 12;
   localparam int unsigned N_CMP_GROUPS   = 6;
   localparam int unsigned N_WET_GROUPS   = 15;
   localparam int unsigned CMP_W          = 2;
   localparam int unsigned ADC_SEL_W      = 3;
   localparam int unsigned WET_W          = 3;
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned POLL_STEP_NS   = 1000;
   localparam int unsigned POLL_STEP_CYC  = (POLL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Pin synchroniser bit positions
   localparam int unsigned PIN_RISE       = 0;
   localparam int unsigned PIN_HOLD       = 1;
   localparam int unsigned PIN_CS_N       = 2;
   localparam int unsigned PIN_SCLK       = 3;
   localparam int unsigned PIN_MOSI       = 4;
   localparam logic [4:0]  PIN_SYNC_RST   = 5'h04;
   // Serial frame: 8 address bits then 24 data bits
   localparam int unsigned ADDR_BITS      = 8;
   localparam int unsigned DATA_BITS      = 24;
   localparam logic [7:0]  ADDR_EVENT     = 8'h01;
   localparam logic [7:0]  ADDR_MISC      = 8'h02;
   localparam logic [7:0]  ADDR_STATUS    = 8'h03;
   // Event register fields
   localparam int unsigned EVT_HIGH_SUPPLY = 0;
   localparam int unsigned EVT_SWITCH_CHG  = 1;
   localparam logic [1:0]  EVENT_RST       = 2'h0;
   localparam logic [9:0]  SINK_SELECT_RST = 10'h000;
   localparam logic [23:0] INPUT_EN_RST    = 24'h000000;
   localparam logic [11:0] CMP_LEVEL_RST   = 12'h000;
   localparam logic [35:0] ADC_SEL_RST     = 36'h000000000;
   localparam logic [44:0] WET_RST         = 45'h0;
   typedef enum logic [1:0] {
      ADC_SET_BANK  = 2'b00,
      ADC_SET_PAIR  = 2'b01,
      ADC_SET_THREE = 2'b10,
      ADC_SET_FIVE  = 2'b11
   } adc_set_e;
endpackage : ovcfg_pkg

// >>> switch_input_ov_and_config.sv
`timescale 1ns/1ns
`default_nettype none
module switch_input_ov_and_config #(
   parameter int unsigned POLL_STEP_CYC = ovcfg_pkg::POLL_STEP_CYC
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         supply_above_rise_i,
   input  wire logic         supply_above_fall_i,
   input  wire logic         spi_cs_n_i,
   input  wire logic         spi_sclk_i,
   input  wire logic         spi_mosi_i,
   output logic              spi_miso_o,
   output logic              spi_miso_oe_n_o,
   output logic              alert_n_o,
   input  wire logic         monitor_run_i,
   input  wire logic [23:0]  input_enable_i,
   input  wire logic [9:0]   sink_select_i,
   input  wire logic [11:0]  comparator_level_group_i,
   input  wire logic [35:0]  adc_level_bank_sel_i,
   input  wire logic [44:0]  wetting_group_setting_i,
   input  wire logic [23:0]  switch_level_i,
   output logic              high_supply_event_bit_o,
   output logic              switch_change_event_o,
   output logic              high_supply_live_bit_o,
   output logic              pending_event_flag_o,
   output logic [23:0]       switch_state_o,
   output logic              monitor_active_o,
   output logic [23:0]       source_on_o,
   output logic [9:0]        sink_on_o,
   output logic [47:0]       comparator_level_o,
   output logic [35:0]       adc_level_sel_o,
   output logic [47:0]       adc_level_kind_o,
   output logic [71:0]       wetting_setting_o
);

   logic [4:0]  pin_meta_reg;
   logic [4:0]  pin_sync_reg;
   logic [4:0]  pin_prev_reg;
   logic [23:0] sw_meta_reg;
   logic [23:0] sw_sync_reg;
   logic        ov_reg;
   logic        ov_enter;
   logic        ov_leave;
   logic        active;
   logic        cs_fall;
   logic        cs_rise;
   logic        cs_low;
   logic        sclk_rise;
   logic        sclk_fall;
   logic [23:0] en_reg;
   logic [9:0]  sink_sel_reg;
   logic [11:0] cmp_cfg_reg;
   logic [35:0] adc_cfg_reg;
   logic [44:0] wet_cfg_reg;
   logic [15:0] tick_cnt_reg;
   logic        tick;
   logic [4:0]  idx_reg;
   logic        step;
   logic        cycle_end;
   logic [23:0] sample_reg;
   logic [23:0] cur_state;
   logic [23:0] baseline_reg;
   logic        first_cycle_reg;
   logic        change_set;
   logic [1:0]  event_reg;
   logic [1:0]  event_next;
   logic [1:0]  set_vec;
   logic [1:0]  clr_mask;
   logic [1:0]  snap_reg;
   logic        read_evt_reg;
   logic        alert_n_reg;
   logic [5:0]  bit_cnt_reg;
   logic [7:0]  addr_reg;
   logic [7:0]  addr_full;
   logic [23:0] tx_reg;
   logic        miso_reg;

   // Wetting group that each input belongs to
   function automatic int wet_group(input int i);
      int g;
      g = 0;
      case (i)
         0, 1:    g = 0;
         2, 3:    g = 1;
         4:       g = 2;
         5:       g = 3;
         6, 7:    g = 4;
         8, 9:    g = 5;
         10:      g = 6;
         11:      g = 7;
         12, 13:  g = 8;
         14, 15:  g = 9;
         16, 17:  g = 10;
         18, 19:  g = 11;
         20, 21:  g = 12;
         22:      g = 13;
         default: g = 14;
      endcase
      return g;
   endfunction : wet_group

   function automatic logic [1:0] adc_kind(input int i);
      logic [1:0] k;
      k = ovcfg_pkg::ADC_SET_FIVE;
      if (i < 12) begin
         k = ovcfg_pkg::ADC_SET_BANK;
      end else if (i < 18) begin
         k = ovcfg_pkg::ADC_SET_PAIR;
      end else if (i < 23) begin
         k = ovcfg_pkg::ADC_SET_THREE;
      end
      return k;
   endfunction : adc_kind

   // Pins and the serial clock come from outside this clock domain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_reg <= ovcfg_pkg::PIN_SYNC_RST;
         pin_sync_reg <= ovcfg_pkg::PIN_SYNC_RST;
         pin_prev_reg <= ovcfg_pkg::PIN_SYNC_RST;
      end else begin
         pin_meta_reg <= {spi_mosi_i, spi_sclk_i, spi_cs_n_i, supply_above_fall_i, supply_above_rise_i};
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_meta_reg <= 24'h000000;
         sw_sync_reg <= 24'h000000;
      end else begin
         sw_meta_reg <= switch_level_i;
         sw_sync_reg <= sw_meta_reg;
      end
   end

   assign cs_low    = ~pin_sync_reg[ovcfg_pkg::PIN_CS_N];
   assign cs_fall   = pin_prev_reg[ovcfg_pkg::PIN_CS_N] & ~pin_sync_reg[ovcfg_pkg::PIN_CS_N];
   assign cs_rise   = ~pin_prev_reg[ovcfg_pkg::PIN_CS_N] & pin_sync_reg[ovcfg_pkg::PIN_CS_N];
   assign sclk_rise = ~pin_prev_reg[ovcfg_pkg::PIN_SCLK] & pin_sync_reg[ovcfg_pkg::PIN_SCLK];
   assign sclk_fall = pin_prev_reg[ovcfg_pkg::PIN_SCLK] & ~pin_sync_reg[ovcfg_pkg::PIN_SCLK];

   // Over-voltage state with hysteresis
   assign ov_enter = ~ov_reg & pin_sync_reg[ovcfg_pkg::PIN_RISE];
   assign ov_leave = ov_reg & ~pin_sync_reg[ovcfg_pkg::PIN_HOLD];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ov_reg <= 1'b0;
      end else if (ov_enter) begin
         ov_reg <= 1'b1;
      end else if (ov_leave) begin
         ov_reg <= 1'b0;
      end
   end

   // One gate stops the scanner at once and every source and sink one clock later, since those outputs are registered
   assign active = monitor_run_i & ~ov_reg;

   // Configuration is captured only while stopped, so a running scan never sees it change
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_reg       <= ovcfg_pkg::INPUT_EN_RST;
         sink_sel_reg <= ovcfg_pkg::SINK_SELECT_RST;
         cmp_cfg_reg  <= ovcfg_pkg::CMP_LEVEL_RST;
         adc_cfg_reg  <= ovcfg_pkg::ADC_SEL_RST;
         wet_cfg_reg  <= ovcfg_pkg::WET_RST;
      end else if (!monitor_run_i) begin
         en_reg       <= input_enable_i;
         sink_sel_reg <= sink_select_i;
         cmp_cfg_reg  <= comparator_level_group_i;
         adc_cfg_reg  <= adc_level_bank_sel_i;
         wet_cfg_reg  <= wetting_group_setting_i;
      end
   end

   // Poll step divider
   always_ff @(posedge clk_i) begin
      if (rst_i || !active) begin
         tick_cnt_reg <= 16'h0000;
      end else if (tick) begin
         tick_cnt_reg <= 16'h0000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
   end

   assign tick = (tick_cnt_reg == 16'(POLL_STEP_CYC - 1));

   // Disabled inputs are passed over without waiting for a tick
   assign step      = active & (tick | ~en_reg[idx_reg]);
   assign cycle_end = step & (idx_reg == 5'(ovcfg_pkg::N_INPUTS - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || !active) begin
         idx_reg <= 5'h00;
      end else if (cycle_end) begin
         idx_reg <= 5'h00;
      end else if (step) begin
         idx_reg <= idx_reg + 5'h01;
      end
   end

   always_comb begin
      cur_state          = sample_reg;
      cur_state[idx_reg] = en_reg[idx_reg] & sw_sync_reg[idx_reg];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_reg <= 24'h000000;
      end else if (step) begin
         sample_reg <= cur_state;
      end
   end

   // Any stop, over-voltage included, makes the next full cycle a fresh baseline
   always_ff @(posedge clk_i) begin
      if (rst_i || !active) begin
         first_cycle_reg <= 1'b1;
      end else if (cycle_end) begin
         first_cycle_reg <= 1'b0;
      end
   end

   assign change_set = cycle_end & (first_cycle_reg | (cur_state != baseline_reg));

   // Status is held, not cleared, while monitoring is halted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         baseline_reg <= 24'h000000;
      end else if (cycle_end) begin
         baseline_reg <= cur_state;
      end
   end

   // Event register: only edges of the over-voltage state set the high-supply bit, so no repeat while it persists
   always_comb begin
      set_vec                             = 2'h0;
      set_vec[ovcfg_pkg::EVT_HIGH_SUPPLY] = ov_enter | ov_leave;
      set_vec[ovcfg_pkg::EVT_SWITCH_CHG]  = change_set;
      clr_mask                            = (cs_rise & read_evt_reg) ? snap_reg : 2'h0;
      // Only bits the host saw are cleared, and a set in the same cycle wins
      event_next                          = (event_reg & ~clr_mask) | set_vec;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_reg   <= ovcfg_pkg::EVENT_RST;
         alert_n_reg <= 1'b1;
      end else begin
         event_reg   <= event_next;
         alert_n_reg <= ~|event_next;
      end
   end

   // Serial port runs regardless of the supply state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_cnt_reg <= 6'h00;
         addr_reg    <= 8'h00;
      end else if (cs_fall) begin
         bit_cnt_reg <= 6'h00;
      end else if (cs_low && sclk_rise) begin
         if (bit_cnt_reg < 6'(ovcfg_pkg::ADDR_BITS)) begin
            addr_reg <= addr_full;
         end
         if (bit_cnt_reg != 6'(ovcfg_pkg::ADDR_BITS + ovcfg_pkg::DATA_BITS)) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         end
      end
   end

   assign addr_full = {addr_reg[6:0], pin_sync_reg[ovcfg_pkg::PIN_MOSI]};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         read_evt_reg <= 1'b0;
         snap_reg     <= 2'h0;
      end else if (cs_fall) begin
         read_evt_reg <= 1'b0;
      end else if (cs_low && sclk_rise && bit_cnt_reg == 6'(ovcfg_pkg::ADDR_BITS - 1)
                   && addr_full == ovcfg_pkg::ADDR_EVENT) begin
         read_evt_reg <= 1'b1;
         snap_reg     <= event_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_reg   <= 24'h000000;
         miso_reg <= 1'b0;
      end else if (cs_fall) begin
         miso_reg <= |event_reg;
      end else if (cs_low && sclk_rise && bit_cnt_reg == 6'(ovcfg_pkg::ADDR_BITS - 1)) begin
         case (addr_full)
            ovcfg_pkg::ADDR_EVENT:  tx_reg <= {22'h000000, event_reg};
            ovcfg_pkg::ADDR_MISC:   tx_reg <= {23'h000000, ov_reg};
            ovcfg_pkg::ADDR_STATUS: tx_reg <= baseline_reg;
            default:                tx_reg <= 24'h000000;
         endcase
      end else if (cs_low && sclk_fall) begin
         if (bit_cnt_reg >= 6'(ovcfg_pkg::ADDR_BITS)) begin
            miso_reg <= tx_reg[23];
            tx_reg   <= {tx_reg[22:0], 1'b0};
         end else begin
            miso_reg <= 1'b0;
         end
      end
   end

   assign spi_miso_o      = miso_reg;
   assign spi_miso_oe_n_o = ~cs_low;

   // Per-input current steering
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         source_on_o <= 24'h000000;
         sink_on_o   <= 10'h000;
      end else begin
         for (int i = 0; i < ovcfg_pkg::N_INPUTS; i++) begin
            if (i < ovcfg_pkg::N_SINK_INPUTS) begin
               source_on_o[i] <= active & en_reg[i] & ~sink_sel_reg[i];
               sink_on_o[i]   <= active & en_reg[i] & sink_sel_reg[i];
            end else begin
               source_on_o[i] <= active & en_reg[i];
            end
         end
      end
   end

   // Per-input threshold and wetting maps; registered so the analog side sees clean levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comparator_level_o <= 48'h000000000000;
         adc_level_sel_o    <= ovcfg_pkg::ADC_SEL_RST;
         adc_level_kind_o   <= 48'h000000000000;
         wetting_setting_o  <= 72'h0;
      end else begin
         for (int i = 0; i < ovcfg_pkg::N_INPUTS; i++) begin
            comparator_level_o[i*2 +: 2] <= cmp_cfg_reg[(i/4)*2 +: 2];
            adc_level_kind_o[i*2 +: 2]   <= adc_kind(i);
            wetting_setting_o[i*3 +: 3]  <= wet_cfg_reg[wet_group(i)*3 +: 3];
         end
         adc_level_sel_o <= adc_cfg_reg;
      end
   end

   assign alert_n_o               = alert_n_reg;
   assign high_supply_event_bit_o = event_reg[ovcfg_pkg::EVT_HIGH_SUPPLY];
   assign switch_change_event_o   = event_reg[ovcfg_pkg::EVT_SWITCH_CHG];
   assign high_supply_live_bit_o  = ov_reg;
   assign pending_event_flag_o    = |event_reg;
   assign switch_state_o          = baseline_reg;
   assign monitor_active_o        = active;

endmodule : switch_input_ov_and_config
`default_nettype wire

// >>> switch_input_ov_and_config_checker.sv
`timescale 1ns/1ns
`default_nettype none
module switch_input_ov_and_config_checker #(
   parameter int unsigned POLL_STEP_CYC = 4
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        supply_above_rise_i,
   input wire logic        supply_above_fall_i,
   input wire logic        spi_cs_n_i,
   input wire logic        spi_miso_oe_n_o,
   input wire logic        alert_n_o,
   input wire logic        high_supply_event_bit_o,
   input wire logic        switch_change_event_o,
   input wire logic        high_supply_live_bit_o,
   input wire logic        pending_event_flag_o,
   input wire logic [23:0] switch_state_o,
   input wire logic        monitor_active_o,
   input wire logic [23:0] source_on_o,
   input wire logic [9:0]  sink_on_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Five samples cover the two-stage synchroniser plus the state update
   chk_live_on_rise: assert property (supply_above_rise_i [*5] |-> high_supply_live_bit_o)
      else $error("live bit missing after supply rise");
   chk_live_off_fall: assert property ((!supply_above_fall_i) [*5] |-> !high_supply_live_bit_o)
      else $error("live bit stuck after supply fall");
   chk_entry_alert: assert property ($rose(high_supply_live_bit_o) |-> high_supply_event_bit_o && !alert_n_o)
      else $error("no event or alert on entry");
   chk_exit_alert: assert property ($fell(high_supply_live_bit_o) |-> high_supply_event_bit_o && !alert_n_o)
      else $error("no event or alert on exit");
   chk_currents_off: assert property (high_supply_live_bit_o |=> source_on_o == 24'h0 && sink_on_o == 10'h0)
      else $error("currents still on in over-voltage");
   chk_monitor_halt: assert property (high_supply_live_bit_o |-> !monitor_active_o)
      else $error("monitoring active in over-voltage");
   chk_no_reentry: assert property (high_supply_live_bit_o && !high_supply_event_bit_o ##1 high_supply_live_bit_o |-> !high_supply_event_bit_o)
      else $error("event raised again while over-voltage stays");
   chk_alert_level: assert property (high_supply_event_bit_o || switch_change_event_o |-> !alert_n_o)
      else $error("alert released with an event pending");
   chk_pending_flag: assert property (pending_event_flag_o == (high_supply_event_bit_o || switch_change_event_o))
      else $error("pending flag disagrees with events");
   chk_status_frozen: assert property (high_supply_live_bit_o [*3] |-> $stable(switch_state_o))
      else $error("status changed in over-voltage");
   chk_sink_exclusive: assert property ((source_on_o[9:0] & sink_on_o) == 10'h0)
      else $error("source and sink on together");
   chk_oe_release: assert property (spi_cs_n_i [*3] |-> spi_miso_oe_n_o)
      else $error("data out driven without chip select");
endmodule : switch_input_ov_and_config_checker
`default_nettype wire

// >>> spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   input  wire logic clk_i,
   input  wire logic miso_i,
   input  wire logic miso_oe_n_i,
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      mosi_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
   end
   // Mode 0, 8 clocks a bit; serial clock stands low outside frames
   task automatic xfer(input logic [7:0] addr, output logic flag, output logic [23:0] data);
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      flag = miso_oe_n_i ? 1'bx : miso_i;
      for (int k = 0; k < 32; k++) begin
         // Unused data-phase line toggles so a stale level is never mistaken for data
         mosi_o <= (k < 8) ? addr[7 - k] : ~mosi_o;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         if (k >= 8) data[31 - k] = miso_oe_n_i ? 1'bx : miso_i;
         sclk_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
      repeat (8) @(posedge clk_i);
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// >>> switch_input_ov_and_config_bench.sv
`timescale 1ns/1ns
`default_nettype none
module switch_input_ov_and_config_bench;
   logic        clk = 1'b0;
   logic        rst, rise, fall, run, cs_n, sclk, mosi, miso, miso_oe_n, alert_n;
   logic        hs_evt, sw_evt, live, pend, mon_act, acc, flag;
   logic [23:0] en, lvl, st, src, seen_src, rd;
   logic [9:0]  snk_sel, snk, seen_snk;
   logic [11:0] cmp;
   logic [35:0] adc_sel_in, adc_sel;
   logic [44:0] wet;
   logic [47:0] cmp_map, kind;
   logic [71:0] wet_map;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          wg [24] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 6, 7, 8, 8, 9, 9, 10, 10, 11, 11, 12, 12, 13, 14};

   always #10 clk = ~clk;
   always @(posedge clk) begin
      seen_src <= acc ? (seen_src | src) : 24'h0;
      seen_snk <= acc ? (seen_snk | snk) : 10'h0;
   end

   switch_input_ov_and_config #(.POLL_STEP_CYC(4)) i_switch_input_ov_and_config (
      .clk_i(clk), .rst_i(rst), .supply_above_rise_i(rise), .supply_above_fall_i(fall),
      .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso),
      .spi_miso_oe_n_o(miso_oe_n), .alert_n_o(alert_n), .monitor_run_i(run), .input_enable_i(en),
      .sink_select_i(snk_sel), .comparator_level_group_i(cmp), .adc_level_bank_sel_i(adc_sel_in),
      .wetting_group_setting_i(wet), .switch_level_i(lvl), .high_supply_event_bit_o(hs_evt),
      .switch_change_event_o(sw_evt), .high_supply_live_bit_o(live), .pending_event_flag_o(pend),
      .switch_state_o(st), .monitor_active_o(mon_act), .source_on_o(src), .sink_on_o(snk),
      .comparator_level_o(cmp_map), .adc_level_sel_o(adc_sel), .adc_level_kind_o(kind),
      .wetting_setting_o(wet_map));

   spi_host_model i_spi_host_model (.clk_i(clk), .miso_i(miso), .miso_oe_n_i(miso_oe_n),
      .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd_reg(input logic [7:0] a, input logic [23:0] exp, input logic f);
      i_spi_host_model.xfer(a, flag, rd);
      check("flag", 72'(flag), 72'(f));
      check("reg", 72'(rd), 72'(exp));
   endtask : rd_reg

   task automatic check_maps(input logic [11:0] c);
      for (int i = 0; i < 24; i++) begin
         check("cmp", 72'(cmp_map[2*i +: 2]), 72'(c[2*(i/4) +: 2]));
         check("kind", 72'(kind[2*i +: 2]), 72'(i < 12 ? 0 : i < 18 ? 1 : i < 23 ? 2 : 3));
         check("wet", 72'(wet_map[3*i +: 3]), 72'(wet[3*wg[i] +: 3]));
      end
      check("adc", 72'(adc_sel), 72'(adc_sel_in));
   endtask : check_maps

   task automatic wait_sw();
      for (int n = 0; n < 3000 && sw_evt !== 1'b1; n++) @(posedge clk);
      check("swchg", 72'(sw_evt), 72'(1));
   endtask : wait_sw

   initial begin
      rst = 1'b1; rise = 1'b0; fall = 1'b0; run = 1'b0; acc = 1'b0;
      // Configuration settled before the run bit is raised
      en = 24'hffffff; snk_sel = 10'h2a5; cmp = 12'he4b; lvl = 24'h5a3cf1;
      adc_sel_in = 36'h9abcdef12; wet = 45'h123456789abc;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      check("alert", 72'(alert_n), 72'(1));
      check("sink", 72'(snk), 72'(0));
      check_maps(12'he4b);
      run <= 1'b1;
      acc <= 1'b1;
      wait_sw();
      check("state", 72'(st), 72'(24'h5a3cf1));
      check("src", 72'(seen_src), 72'({14'h3fff, ~snk_sel}));
      check("snk", 72'(seen_snk), 72'(snk_sel));
      acc <= 1'b0;
      cmp <= 12'h1b6;
      repeat (8) @(posedge clk);
      check_maps(12'he4b);
      rd_reg(8'h03, 24'h5a3cf1, 1'b1);
      rd_reg(8'h01, 24'h000002, 1'b1);
      repeat (6) @(posedge clk);
      check("alert", 72'(alert_n), 72'(1));
      fall <= 1'b1;
      repeat (4) @(posedge clk);
      rise <= 1'b1;
      repeat (8) @(posedge clk);
      check("live", 72'(live), 72'(1));
      check("hs", 72'(hs_evt), 72'(1));
      check("alert", 72'(alert_n), 72'(0));
      check("mon", 72'(mon_act), 72'(0));
      check("src", 72'(src), 72'(0));
      lvl <= 24'h0f0f33;
      rd_reg(8'h02, 24'h000001, 1'b1);
      rd_reg(8'h03, 24'h5a3cf1, 1'b1);
      check("alert", 72'(alert_n), 72'(0));
      rd_reg(8'h01, 24'h000001, 1'b1);
      repeat (30) @(posedge clk);
      check("alert", 72'(alert_n), 72'(1));
      check("hs", 72'(hs_evt), 72'(0));
      rd_reg(8'h02, 24'h000001, 1'b0);
      rise <= 1'b0;
      repeat (4) @(posedge clk);
      fall <= 1'b0;
      repeat (8) @(posedge clk);
      check("live", 72'(live), 72'(0));
      check("hs", 72'(hs_evt), 72'(1));
      check("alert", 72'(alert_n), 72'(0));
      wait_sw();
      check("state", 72'(st), 72'(24'h0f0f33));
      rd_reg(8'h01, 24'h000003, 1'b1);
      // Stopped again: the held comparator map now takes effect, inputs 0 and 23 are left out
      run <= 1'b0;
      en  <= 24'h7ffffe;
      repeat (4) @(posedge clk);
      check_maps(12'h1b6);
      run <= 1'b1;
      acc <= 1'b1;
      wait_sw();
      check("state", 72'(st), 72'(24'h0f0f32));
      check("src", 72'(seen_src), 72'({14'h1fff, 10'h15a}));
      check("snk", 72'(seen_snk), 72'(10'h2a4));
      rd_reg(8'h01, 24'h000002, 1'b1);
      // A later cycle compares against the stored baseline
      lvl <= 24'h0f0f31;
      wait_sw();
      check("state", 72'(st), 72'(24'h0f0f30));
      stop_test();
   end

   // The run takes under 10000 cycles; allow ten times that
   initial begin
      #2000000;
      n_mismatch++;
      stop_test();
   end
endmodule : switch_input_ov_and_config_bench

bind switch_input_ov_and_config switch_input_ov_and_config_checker #(.POLL_STEP_CYC(POLL_STEP_CYC)) i_chk (
   .clk_i, .rst_i, .supply_above_rise_i, .supply_above_fall_i, .spi_cs_n_i, .spi_miso_oe_n_o,
   .alert_n_o, .high_supply_event_bit_o, .switch_change_event_o, .high_supply_live_bit_o,
   .pending_event_flag_o, .switch_state_o, .monitor_active_o, .source_on_o, .sink_on_o);
`default_nettype wire
